// ===== pkg/bks_bus_if.sv
// Purpose: Memory bus between the sequencer and its select decoder.
// Assumes: All strobes active low.
// Notes: Combinational selects; the top registers them before the pins.
`timescale 1ns/1ps
interface bks_bus_if;
	logic [15:0] addr;
	logic rd_n;
	logic wr_n;
	logic ps_n;
	logic ds_n;
	logic rom_sel_n;
	logic sram_sel_n;
	modport seq (output addr, output rd_n, output wr_n, output ps_n, output ds_n,
		input rom_sel_n, input sram_sel_n);
	modport dec (input addr, input rd_n, input wr_n, input ps_n, input ds_n,
		output rom_sel_n, output sram_sel_n);
endinterface

// ===== pkg/bks_pkg.sv
// Purpose: Shared constants and types for the boot kernel sequencer.
// Assumes: 100 MHz system clock; byte-wide boot ROM and external SRAM.
// Notes: Times are kept in their own units; cycle counts derive from them.
package bks_pkg;
	localparam int unsigned CLK_MHZ = 100;
	localparam int unsigned CLK_KHZ = CLK_MHZ * 1000;
	localparam longint unsigned CLK_HZ = 64'd100000000;

	// Supply settle, load deadline, pause and watchdog times
	localparam int unsigned T_RESET_MS = 20;
	localparam int unsigned T_LOADOK_MS = 150;
	localparam int unsigned T_PAUSE_MS = 2;
	localparam int unsigned T_WDOG_HALF_MS = 250;
	localparam int unsigned T_WDOG_MAX_MS = 1000;
	localparam int unsigned T_WDOG_PULSE_US = 15;
	localparam int unsigned RESET_CYC = T_RESET_MS * CLK_KHZ;
	localparam int unsigned LOADOK_CYC = T_LOADOK_MS * CLK_KHZ;
	localparam int unsigned PAUSE_CYC = T_PAUSE_MS * CLK_KHZ;
	localparam int unsigned WDOG_HALF_CYC = T_WDOG_HALF_MS * CLK_KHZ;
	localparam int unsigned WDOG_MAX_CYC = T_WDOG_MAX_MS * CLK_KHZ;
	localparam int unsigned WDOG_PULSE_CYC = T_WDOG_PULSE_US * CLK_MHZ;

	// Strobe widths: 15 wait states at power-up, then faster copy cycles
	localparam int unsigned WAIT_STATES = 15;
	localparam int unsigned T_FETCH_NS = 450;
	localparam int unsigned T_ROM_COPY_NS = 310;
	localparam int unsigned T_SRAM_WR_NS = 70;
	localparam int unsigned FETCH_CYC = (T_FETCH_NS * CLK_MHZ + 999) / 1000;
	localparam int unsigned ROM_COPY_CYC = (T_ROM_COPY_NS * CLK_MHZ + 999) / 1000;
	localparam int unsigned SRAM_WR_CYC = (T_SRAM_WR_NS * CLK_MHZ + 999) / 1000;

	// Memory map
	localparam logic [15:0] ROM_BOOT_BASE = 16'hC000;
	localparam logic [15:0] ROM_PROG_BASE = 16'hC600;
	localparam int unsigned BOOT_BYTES = 1536;
	localparam int unsigned ONCHIP_WORDS = 512;
	localparam int unsigned PROG_WORDS_DEF = 4096;
	localparam int unsigned PROG_WORDS_MAX = 14848;
	localparam int unsigned IDX_W = 14;
	localparam logic [7:0] SUM_GOOD = 8'h00;

	// Core clock synthesis from the crystal
	localparam longint unsigned XTAL_HZ = 64'd3869180;
	localparam longint unsigned PLL_MULT = 64'd10;
	localparam longint unsigned CORE_HZ = XTAL_HZ * PLL_MULT;
	localparam int unsigned NCO_W = 24;
	localparam logic [NCO_W-1:0] NCO_INC =
		NCO_W'((64'd2 * CORE_HZ * (64'd1 << NCO_W)) / CLK_HZ);

	// Pin synchroniser: {supply, key rows, rom data}
	localparam int unsigned SYNC_W = 13;
	localparam logic [SYNC_W-1:0] SYNC_RST = 13'h0F00;
	localparam int unsigned SYNC_SUPPLY = 12;
	localparam int unsigned SYNC_KEY_LO = 8;

	typedef enum logic [2:0] {
		ST_POWER = 3'h0,
		ST_FETCH = 3'h1,
		ST_PAUSE = 3'h2,
		ST_COPY = 3'h3,
		ST_CHECK = 3'h4,
		ST_RUN = 3'h5,
		ST_FAIL = 3'h6
	} bks_state_t;

	typedef enum logic [1:0] {
		PH_GAP = 2'h0,
		PH_READ = 2'h1,
		PH_WRITE = 2'h2
	} bks_phase_t;
endpackage

// ===== rtl/bks_decoder.sv
// Purpose: Chip-select glue for boot ROM and external SRAM.
// Assumes: Program space upper quarter is ROM, lowest quarter is SRAM.
// Notes: A data-space window also reaches the SRAM for run-time use.
`timescale 1ns/1ps
module bks_decoder import bks_pkg::*; (
	// Bus from the sequencer
	bks_bus_if.dec bus
);
	logic a15;
	logic a14;
	logic a5;
	logic a4;
	logic access;
	assign a15 = bus.addr[15];
	assign a14 = bus.addr[14];
	assign a5 = bus.addr[5];
	assign a4 = bus.addr[4];
	assign access = ~bus.rd_n | ~bus.wr_n;
	assign bus.rom_sel_n = ~(~bus.ps_n & a15 & a14 & ~bus.rd_n);
	assign bus.sram_sel_n = ~(access & ((~bus.ps_n & ~a15 & ~a14) |
		(~bus.ds_n & a15 & a14 & ~a5 & a4)));
endmodule // bks_decoder

// ===== rtl/bks_top.sv
// Purpose: Power-up sequencing and boot load of the processor kernel.
// Assumes: ROM data stable before the end of each read strobe.
// Notes: Core clock output is NCO-derived, so it carries cycle jitter.
`timescale 1ns/1ps
// Overview of operation
// - Processor reset goes high about 20 ms after supply reaches 3.3 V.
// - Strap inputs C and B are held low across reset release.
// - Strap A stays high: key interrupt never pulled low during reset.
// - Load-success flag rises within 150 ms of power-on after a good load.
// - Boot page select is high whenever reset is asserted.
// - Watchdog kick changes state at least once per second while running.
// - Every watchdog kick level lasts at least 15 microseconds.
// - Core clock is crystal 3.86918 MHz times ten, 38.6918 MHz.
// - After reset, read 1536 boot bytes from ROM starting at $C000.
// - Power-up accesses use 15 wait states, ROM select low about 450 ns.
// - Pause a few milliseconds after boot block, then copy full program.
// - First 512 words go on-chip; SRAM select stays idle until then.
// - Copy reads select ROM about 310 ns, SRAM writes about 70 ns.
// - Selects decode from A15, A14, A5, A4 and the bus strobes.
// - Names ending in _N are active low, others active high.
module bks_top import bks_pkg::*; #(
	parameter int unsigned RESET_CYCLES = RESET_CYC,
	parameter int unsigned LOAD_DEADLINE_CYCLES = LOADOK_CYC,
	parameter int unsigned PAUSE_CYCLES = PAUSE_CYC,
	parameter int unsigned WDOG_HALF_CYCLES = WDOG_HALF_CYC,
	parameter int unsigned PROG_WORDS = PROG_WORDS_DEF
) (
	// Clock, reset, enable
	input wire logic CLOCK,
	input wire logic RST_N,
	input wire logic CE,
	// Pins from supply monitor and keypad
	input wire logic SUPPLY_OK,
	input wire logic [3:0] KEY_ROW_N,
	// Memory bus
	input wire logic [7:0] ROM_DATA,
	output logic [15:0] ADDR,
	output logic RD_N,
	output logic WR_N,
	output logic PROGRAM_SPACE_STROBE_N,
	output logic DATA_SPACE_STROBE_N,
	output logic ROM_SELECT_N,
	output logic SRAM_SELECT_N,
	output logic [7:0] SRAM_DATA,
	// Processor kernel control
	output logic PROC_RESET_N,
	output logic MODE_C,
	output logic MODE_B,
	output logic KEY_INTERRUPT_N_O,
	output logic KEY_INTERRUPT_N_OE_N,
	output logic BOOT_PAGE_SELECT,
	output logic LOAD_OK_FLAG,
	output logic WATCHDOG_KICK,
	output logic CORE_CLK
);
	if (WDOG_HALF_CYCLES < WDOG_PULSE_CYC || WDOG_HALF_CYCLES > WDOG_MAX_CYC)
		$error("watchdog half period out of range");
	if (PROG_WORDS <= ONCHIP_WORDS || PROG_WORDS > PROG_WORDS_MAX)
		$error("program length unsupported");
	if (RESET_CYCLES < 1 || PAUSE_CYCLES < 1 || LOAD_DEADLINE_CYCLES < RESET_CYCLES)
		$error("timing parameters unsupported");

	localparam logic [IDX_W-1:0] BOOT_LAST = IDX_W'(BOOT_BYTES);
	localparam logic [IDX_W-1:0] PROG_LAST = IDX_W'(PROG_WORDS);
	localparam logic [IDX_W-1:0] ONCHIP_END = IDX_W'(ONCHIP_WORDS);
	localparam logic [31:0] RESET_END = 32'(RESET_CYCLES - 1);
	localparam logic [31:0] PAUSE_END = 32'(PAUSE_CYCLES - 1);
	localparam logic [31:0] DEADLINE_END = 32'(LOAD_DEADLINE_CYCLES - 1);
	localparam logic [31:0] WDOG_END = 32'(WDOG_HALF_CYCLES - 1);
	localparam logic [7:0] FETCH_END = 8'(FETCH_CYC - 1);
	localparam logic [7:0] COPY_END = 8'(ROM_COPY_CYC - 1);
	localparam logic [7:0] WRITE_END = 8'(SRAM_WR_CYC - 1);

	bks_bus_if bus ();

	bks_decoder u_decoder (
		.bus(bus.dec)
	);

	// Pin synchronisers: a bit moves only once stages two and three agree
	logic [SYNC_W-1:0] sync1_q;
	logic [SYNC_W-1:0] sync2_q;
	logic [SYNC_W-1:0] sync3_q;
	logic [SYNC_W-1:0] filt_q;
	logic supply_f;
	logic [3:0] keys_f;
	logic [7:0] rom_f;

	always_ff @(posedge CLOCK or negedge RST_N) begin
		if (!RST_N) begin
			sync1_q <= SYNC_RST;
			sync2_q <= SYNC_RST;
			sync3_q <= SYNC_RST;
			filt_q <= SYNC_RST;
		end else if (CE) begin
			sync1_q <= {SUPPLY_OK, KEY_ROW_N, ROM_DATA};
			sync2_q <= sync1_q;
			sync3_q <= sync2_q;
			filt_q <= ((sync2_q ~^ sync3_q) & sync2_q) | ((sync2_q ^ sync3_q) & filt_q);
		end
	end

	assign supply_f = filt_q[SYNC_SUPPLY];
	assign keys_f = filt_q[SYNC_KEY_LO +: 4];
	assign rom_f = filt_q[7:0];

	// Boot sequencer
	bks_state_t state_q;
	bks_phase_t ph_q;
	logic [IDX_W-1:0] idx_q;
	logic [7:0] acc_q;
	logic [31:0] timer_q;
	logic [31:0] since_on_q;
	logic [15:0] addr_q;
	logic rd_n_q;
	logic wr_n_q;
	logic ps_n_q;
	logic [7:0] data_q;
	logic [7:0] sum_q;
	logic ext_write;

	assign ext_write = (state_q == ST_COPY) && (idx_q >= ONCHIP_END);

	always_ff @(posedge CLOCK or negedge RST_N) begin
		if (!RST_N) begin
			since_on_q <= '0;
		end else if (CE) begin
			if (!supply_f)
				since_on_q <= '0;
			else if (since_on_q != DEADLINE_END)
				since_on_q <= since_on_q + 32'h0000_0001;
		end
	end

	always_ff @(posedge CLOCK or negedge RST_N) begin
		if (!RST_N) begin
			state_q <= ST_POWER;
			ph_q <= PH_GAP;
			idx_q <= '0;
			acc_q <= '0;
			timer_q <= '0;
			addr_q <= '0;
			rd_n_q <= 1'b1;
			wr_n_q <= 1'b1;
			ps_n_q <= 1'b1;
			data_q <= '0;
			sum_q <= '0;
		end else if (CE) begin
			if (!supply_f) begin
				state_q <= ST_POWER;
				ph_q <= PH_GAP;
				timer_q <= '0;
				rd_n_q <= 1'b1;
				wr_n_q <= 1'b1;
				ps_n_q <= 1'b1;
			end else if (since_on_q == DEADLINE_END && state_q != ST_RUN) begin
				state_q <= ST_FAIL;
				rd_n_q <= 1'b1;
				wr_n_q <= 1'b1;
				ps_n_q <= 1'b1;
			end else begin
				case (state_q)
				ST_POWER: begin
					if (timer_q == RESET_END) begin
						state_q <= ST_FETCH;
						idx_q <= '0;
						sum_q <= '0;
						ph_q <= PH_GAP;
					end else begin
						timer_q <= timer_q + 32'h0000_0001;
					end
				end
				ST_FETCH, ST_COPY: begin
					case (ph_q)
					PH_GAP: begin
						if (state_q == ST_FETCH && idx_q == BOOT_LAST) begin
							state_q <= ST_PAUSE;
							timer_q <= '0;
						end else if (state_q == ST_COPY && idx_q == PROG_LAST) begin
							state_q <= ST_CHECK;
						end else begin
							ph_q <= PH_READ;
							rd_n_q <= 1'b0;
							ps_n_q <= 1'b0;
							if (state_q == ST_FETCH) begin
								addr_q <= ROM_BOOT_BASE + 16'(idx_q);
								acc_q <= FETCH_END;
							end else begin
								addr_q <= ROM_PROG_BASE + 16'(idx_q);
								acc_q <= COPY_END;
							end
						end
					end
					PH_READ: begin
						if (acc_q != 8'h00) begin
							acc_q <= acc_q - 8'h01;
						end else begin
							rd_n_q <= 1'b1;
							data_q <= rom_f;
							if (state_q == ST_COPY)
								sum_q <= sum_q + rom_f;
							if (ext_write) begin
								ph_q <= PH_WRITE;
								addr_q <= 16'(idx_q);
								wr_n_q <= 1'b0;
								acc_q <= WRITE_END;
							end else begin
								ps_n_q <= 1'b1;
								idx_q <= idx_q + 1'b1;
								ph_q <= PH_GAP;
							end
						end
					end
					PH_WRITE: begin
						if (acc_q != 8'h00) begin
							acc_q <= acc_q - 8'h01;
						end else begin
							wr_n_q <= 1'b1;
							ps_n_q <= 1'b1;
							idx_q <= idx_q + 1'b1;
							ph_q <= PH_GAP;
						end
					end
					default: ph_q <= PH_GAP;
					endcase
				end
				ST_PAUSE: begin
					if (timer_q == PAUSE_END) begin
						state_q <= ST_COPY;
						idx_q <= '0;
						ph_q <= PH_GAP;
					end else begin
						timer_q <= timer_q + 32'h0000_0001;
					end
				end
				ST_CHECK: begin
					if (sum_q == SUM_GOOD)
						state_q <= ST_RUN;
					else
						state_q <= ST_FAIL;
				end
				ST_RUN: state_q <= ST_RUN;
				ST_FAIL: state_q <= ST_FAIL;
				default: state_q <= ST_POWER;
				endcase
			end
		end
	end

	assign bus.addr = addr_q;
	assign bus.rd_n = rd_n_q;
	assign bus.wr_n = wr_n_q;
	assign bus.ps_n = ps_n_q;
	assign bus.ds_n = 1'b1;

	// Pin registers; selects decode the same strobes, so both reach the pins together
	always_ff @(posedge CLOCK or negedge RST_N) begin
		if (!RST_N) begin
			ADDR <= '0;
			RD_N <= 1'b1;
			WR_N <= 1'b1;
			PROGRAM_SPACE_STROBE_N <= 1'b1;
			DATA_SPACE_STROBE_N <= 1'b1;
			ROM_SELECT_N <= 1'b1;
			SRAM_SELECT_N <= 1'b1;
			SRAM_DATA <= '0;
		end else if (CE) begin
			ADDR <= addr_q;
			RD_N <= rd_n_q;
			WR_N <= wr_n_q;
			PROGRAM_SPACE_STROBE_N <= ps_n_q;
			DATA_SPACE_STROBE_N <= bus.ds_n;
			ROM_SELECT_N <= bus.rom_sel_n;
			SRAM_SELECT_N <= bus.sram_sel_n;
			SRAM_DATA <= data_q;
		end
	end

	// Kernel control pins
	always_ff @(posedge CLOCK or negedge RST_N) begin
		if (!RST_N) begin
			PROC_RESET_N <= 1'b0;
			MODE_C <= 1'b0;
			MODE_B <= 1'b0;
			KEY_INTERRUPT_N_O <= 1'b0;
			KEY_INTERRUPT_N_OE_N <= 1'b1;
			BOOT_PAGE_SELECT <= 1'b1;
			LOAD_OK_FLAG <= 1'b0;
		end else if (CE) begin
			PROC_RESET_N <= (state_q != ST_POWER);
			MODE_C <= 1'b0;
			MODE_B <= 1'b0;
			KEY_INTERRUPT_N_O <= 1'b0;
			// Released while in reset so the pull-up sets strap A high
			KEY_INTERRUPT_N_OE_N <= (state_q == ST_POWER) || (&keys_f);
			BOOT_PAGE_SELECT <= (state_q != ST_RUN);
			LOAD_OK_FLAG <= (state_q == ST_RUN);
		end
	end

	// Watchdog: each level held a full half period, which may be as short as the minimum
	logic [31:0] wdog_q;
	always_ff @(posedge CLOCK or negedge RST_N) begin
		if (!RST_N) begin
			wdog_q <= '0;
			WATCHDOG_KICK <= 1'b0;
		end else if (CE) begin
			if (state_q != ST_RUN) begin
				wdog_q <= '0;
				WATCHDOG_KICK <= 1'b0;
			end else if (wdog_q == WDOG_END) begin
				wdog_q <= '0;
				WATCHDOG_KICK <= ~WATCHDOG_KICK;
			end else begin
				wdog_q <= wdog_q + 32'h0000_0001;
			end
		end
	end

	// Core clock: fractional toggle rate, average set by the truncated NCO_INC, edges jitter one cycle
	logic [NCO_W-1:0] nco_q;
	logic nco_carry;
	logic [NCO_W-1:0] nco_sum;
	assign {nco_carry, nco_sum} = {1'b0, nco_q} + {1'b0, NCO_INC};
	always_ff @(posedge CLOCK or negedge RST_N) begin
		if (!RST_N) begin
			nco_q <= '0;
			CORE_CLK <= 1'b0;
		end else if (CE) begin
			nco_q <= nco_sum;
			if (nco_carry)
				CORE_CLK <= ~CORE_CLK;
		end
	end
endmodule // bks_top

// ===== verif/bks_rom_model.sv
// Purpose: Boot ROM model for the sequencer bench.
// Assumes: Copy image of PROG_WORDS bytes summing to zero.
// Notes: Idle bus shows the inverse of the last byte.
`timescale 1ns/1ps
module bks_rom_model import bks_pkg::*; #(
	parameter int unsigned PROG_WORDS = 520
) (
	// Bus side
	input wire logic clock,
	input wire logic [15:0] addr,
	input wire logic select_n,
	output logic [7:0] data
);
	logic [7:0] last_q = 8'hA5;
	logic [7:0] word;
	always_comb begin
		word = addr[7:0] ^ 8'h5A;
		if (addr >= ROM_PROG_BASE) begin
			word = (addr - ROM_PROG_BASE == 16'(PROG_WORDS - 1)) ? 8'(1025 - PROG_WORDS) : 8'h01;
		end
	end
	assign data = select_n ? ~last_q : word;
	always_ff @(posedge clock) begin
		if (!select_n) begin
			last_q <= word;
		end
	end
endmodule // bks_rom_model

// ===== verif/bks_top_properties.sv
// Purpose: Port checks for the boot kernel sequencer.
// Assumes: Bound to bks_top from the test top.
// Notes: Strobe widths are measured by small counters.
`timescale 1ns/1ps
module bks_top_properties import bks_pkg::*; #(
	parameter int unsigned RESET_CYCLES = RESET_CYC,
	parameter int unsigned KICK_LIMIT = WDOG_MAX_CYC
) (
	// Clock and reset
	input wire logic CLOCK,
	input wire logic RST_N,
	// Watched pins
	input wire logic SUPPLY_OK,
	input wire logic [15:0] ADDR,
	input wire logic RD_N,
	input wire logic ROM_SELECT_N,
	input wire logic SRAM_SELECT_N,
	input wire logic PROC_RESET_N,
	input wire logic MODE_C,
	input wire logic MODE_B,
	input wire logic KEY_INTERRUPT_N_OE_N,
	input wire logic BOOT_PAGE_SELECT,
	input wire logic LOAD_OK_FLAG,
	input wire logic WATCHDOG_KICK
);
	logic [31:0] sup_q, kick_q;
	logic [15:0] wa_q, cp_q;
	logic [7:0] rw_q, sw_q;
	default clocking @(posedge CLOCK); endclocking
	default disable iff (!RST_N);
	always_ff @(posedge CLOCK or negedge RST_N) begin
		if (!RST_N) begin
			sup_q <= '0;
			kick_q <= '0;
			wa_q <= '0;
			cp_q <= '0;
			rw_q <= '0;
			sw_q <= '0;
		end else begin
			sup_q <= SUPPLY_OK ? sup_q + 32'h0000_0001 : '0;
			kick_q <= ($changed(WATCHDOG_KICK) || !LOAD_OK_FLAG) ? '0 : kick_q + 32'h0000_0001;
			// Address taken while selected; a copy write moves it as the select rises
			wa_q <= ROM_SELECT_N ? wa_q : ADDR;
			rw_q <= ROM_SELECT_N ? '0 : rw_q + 8'h01;
			sw_q <= SRAM_SELECT_N ? '0 : sw_q + 8'h01;
			cp_q <= !PROC_RESET_N ? '0 : cp_q + 16'($fell(ROM_SELECT_N) && ADDR >= ROM_PROG_BASE);
		end
	end
	chk_reset_delay: assert property (
		$rose(PROC_RESET_N) |-> sup_q >= RESET_CYCLES && sup_q <= RESET_CYCLES + 12)
		else $error("processor reset released off its delay");
	chk_mode_straps: assert property (
		$rose(PROC_RESET_N) |-> !MODE_C && !MODE_B)
		else $error("mode straps high at reset release");
	chk_strap_a: assert property (
		!PROC_RESET_N |-> KEY_INTERRUPT_N_OE_N)
		else $error("key line driven during reset");
	chk_page_reset: assert property (
		!PROC_RESET_N |-> BOOT_PAGE_SELECT)
		else $error("boot page select low during reset");
	chk_loaded_run: assert property (
		LOAD_OK_FLAG |-> PROC_RESET_N && !BOOT_PAGE_SELECT)
		else $error("load flag high outside run");
	chk_rom_width: assert property (
		$rose(ROM_SELECT_N) |-> rw_q == (wa_q < ROM_PROG_BASE ? FETCH_CYC : ROM_COPY_CYC))
		else $error("rom select width wrong");
	chk_sram_width: assert property (
		$rose(SRAM_SELECT_N) |-> sw_q == SRAM_WR_CYC)
		else $error("sram select width wrong");
	chk_sram_late: assert property (
		!SRAM_SELECT_N |-> cp_q > ONCHIP_WORDS)
		else $error("sram selected before on-chip words done");
	chk_rom_decode: assert property (
		$fell(RD_N) && ADDR[15:14] == 2'h3 |-> $fell(ROM_SELECT_N))
		else $error("rom select missed a read");
	chk_kick_width: assert property (
		$changed(WATCHDOG_KICK) && LOAD_OK_FLAG |-> kick_q >= WDOG_PULSE_CYC - 1)
		else $error("watchdog level too short");
	chk_kick_alive: assert property (
		LOAD_OK_FLAG |-> kick_q < KICK_LIMIT)
		else $error("watchdog stalled");
	cov_loaded: cover property ($rose(LOAD_OK_FLAG));
	cov_sram_write: cover property ($fell(SRAM_SELECT_N));
	cov_kick: cover property (LOAD_OK_FLAG && $changed(WATCHDOG_KICK));
endmodule // bks_top_properties

// ===== verif/test_boot_kernel_sequencer.sv
// Purpose: Self-checking bench for the boot kernel sequencer.
// Assumes: Shortened reset, pause, image and watchdog counts.
// Notes: Fetch length is fixed, so the load dominates run time.
`timescale 1ns/1ps
module test_boot_kernel_sequencer import bks_pkg::*;;
	localparam int unsigned P_RST = 100;
	localparam int unsigned P_PAUSE = 50;
	localparam int unsigned P_DEAD = 200000;
	localparam int unsigned P_HALF = 1500;
	localparam int unsigned P_WORDS = 520;
	logic CLOCK, RST_N, SUPPLY_OK;
	logic [3:0] KEY_ROW_N;
	logic [7:0] ROM_DATA;
	logic [15:0] ADDR;
	logic RD_N, ROM_SELECT_N, SRAM_SELECT_N, PROC_RESET_N, MODE_C, MODE_B;
	logic KEY_INTERRUPT_N_OE_N, BOOT_PAGE_SELECT, LOAD_OK_FLAG, WATCHDOG_KICK, CORE_CLK;
	logic WR_N, PROGRAM_SPACE_STROBE_N, DATA_SPACE_STROBE_N, KEY_INTERRUPT_N_O;
	logic [7:0] SRAM_DATA;
	int err_total, num_checks, cyc, t_up;
	bks_top #(.RESET_CYCLES(P_RST), .LOAD_DEADLINE_CYCLES(P_DEAD), .PAUSE_CYCLES(P_PAUSE),
		.WDOG_HALF_CYCLES(P_HALF), .PROG_WORDS(P_WORDS)) i_dut (
		.CLOCK(CLOCK), .RST_N(RST_N), .CE(1'b1), .SUPPLY_OK(SUPPLY_OK), .KEY_ROW_N(KEY_ROW_N),
		.ROM_DATA(ROM_DATA), .ADDR(ADDR), .RD_N(RD_N), .WR_N(WR_N),
		.PROGRAM_SPACE_STROBE_N(PROGRAM_SPACE_STROBE_N),
		.DATA_SPACE_STROBE_N(DATA_SPACE_STROBE_N), .ROM_SELECT_N(ROM_SELECT_N),
		.SRAM_SELECT_N(SRAM_SELECT_N), .SRAM_DATA(SRAM_DATA),
		.PROC_RESET_N(PROC_RESET_N), .MODE_C(MODE_C), .MODE_B(MODE_B),
		.KEY_INTERRUPT_N_O(KEY_INTERRUPT_N_O), .KEY_INTERRUPT_N_OE_N(KEY_INTERRUPT_N_OE_N),
		.BOOT_PAGE_SELECT(BOOT_PAGE_SELECT), .LOAD_OK_FLAG(LOAD_OK_FLAG),
		.WATCHDOG_KICK(WATCHDOG_KICK), .CORE_CLK(CORE_CLK));
	bks_rom_model #(.PROG_WORDS(P_WORDS)) i_rom (.clock(CLOCK), .addr(ADDR),
		.select_n(ROM_SELECT_N), .data(ROM_DATA));
	initial begin
		CLOCK = 1'b0;
		forever #5 CLOCK = ~CLOCK;
	end
	task automatic check(input logic [31:0] seen, input logic [31:0] exp);
		num_checks++;
		if (seen !== exp) begin
			err_total++;
			$display("BAD t=%0t seen=%h exp=%h", $time, seen, exp);
		end
	endtask
	task automatic close_out();
		$display("checks=%0d mismatches=%0d", num_checks, err_total);
		if (err_total == 0 && num_checks > 0) begin
			$display("Result: passed");
		end else begin
			$display("Result: failed");
		end
		$finish;
	endtask
	// Ceiling above the expected ~101k cycles
	always @(posedge CLOCK) begin
		cyc++;
		if (cyc == 120000) begin
			err_total++;
			close_out();
		end
	end
	task automatic tick(input int n);
		repeat (n) @(negedge CLOCK);
	endtask
	task automatic test_power();
		check({PROC_RESET_N, BOOT_PAGE_SELECT, KEY_INTERRUPT_N_OE_N, LOAD_OK_FLAG}, 4'h6);
		SUPPLY_OK = 1'b1;
		while (PROC_RESET_N !== 1'b1 && t_up < 1000) begin
			tick(1);
			t_up++;
		end
		check(t_up >= P_RST && t_up <= P_RST + 12, 1);
		check({MODE_C, MODE_B}, 2'h0);
		check(KEY_INTERRUPT_N_OE_N, 1);
		$display("power test done");
	endtask
	task automatic test_load();
		int n = 0, fe = 0, cp = 0, wr = 0, idle = 0, pz = 0, rw = 0, fw = 0, cw = 0;
		int sw = 0, ws = 0, wc = 0;
		logic rp = 1'b1, rs = 1'b1, ss = 1'b1;
		logic [15:0] fa = '0, wa = '0;
		logic [10:0] sd = '0;
		while (LOAD_OK_FLAG !== 1'b1 && n < P_DEAD) begin
			tick(1);
			n++;
			if (rp && !RD_N) begin
				if (ADDR < ROM_PROG_BASE) begin
					if (fe == 0) fa = ADDR;
					fe++;
				end else begin
					if (cp == 0) pz = idle;
					cp++;
				end
			end
			idle = RD_N ? idle + 1 : 0;
			if (!ROM_SELECT_N) rw++;
			else if (!rs) begin
				if (cp == 0) fw = rw;
				else cw = rw;
				rw = 0;
			end
			if (!SRAM_SELECT_N) begin
				sw++;
				if (ss) begin
					wr++;
					if (wr == 1) wa = ADDR;
					if (wr == 1) wc = cp;
					if (wr == 1) sd = {WR_N, PROGRAM_SPACE_STROBE_N, DATA_SPACE_STROBE_N, SRAM_DATA};
				end
			end else if (!ss) begin
				ws = sw;
				sw = 0;
			end
			rp = RD_N;
			rs = ROM_SELECT_N;
			ss = SRAM_SELECT_N;
		end
		check(LOAD_OK_FLAG, 1);
		check(n + t_up < P_DEAD, 1);
		check(fa, ROM_BOOT_BASE);
		check(fe, BOOT_BYTES);
		check(fw, FETCH_CYC);
		check(pz >= P_PAUSE, 1);
		check(cp, P_WORDS);
		check(wr, P_WORDS - ONCHIP_WORDS);
		check(wa, ONCHIP_WORDS);
		check(wc, ONCHIP_WORDS + 1);
		check(cw, ROM_COPY_CYC);
		check(ws, SRAM_WR_CYC);
		check(sd, {3'h1, 8'h01});
		$display("load test done");
	endtask
	task automatic test_run();
		int h, r;
		logic k, c;
		for (int j = 0; j < 2; j++) begin
			k = WATCHDOG_KICK;
			h = 0;
			while (WATCHDOG_KICK === k && h < 2 * P_HALF + 10) begin
				tick(1);
				h++;
			end
			check(h <= 2 * P_HALF, 1);
			if (j == 1) check(h >= WDOG_PULSE_CYC, 1);
		end
		r = 0;
		c = CORE_CLK;
		repeat (10000) begin
			tick(1);
			r += int'(!c && CORE_CLK);
			c = CORE_CLK;
		end
		check(r >= 3868 && r <= 3870, 1);
		$display("run test done");
	endtask
	task automatic test_rerun();
		KEY_ROW_N = 4'hD;
		tick(8);
		check({KEY_INTERRUPT_N_O, KEY_INTERRUPT_N_OE_N}, 2'h0);
		RST_N = 1'b0;
		tick(2);
		check({PROC_RESET_N, BOOT_PAGE_SELECT, KEY_INTERRUPT_N_OE_N, LOAD_OK_FLAG}, 4'h6);
		RST_N = 1'b1;
		tick(40);
		check({PROC_RESET_N, BOOT_PAGE_SELECT, KEY_INTERRUPT_N_OE_N}, 3'h3);
		KEY_ROW_N = 4'hF;
		$display("rerun test done");
	endtask
	initial begin
		RST_N = 1'b0;
		SUPPLY_OK = 1'b0;
		KEY_ROW_N = 4'hF;
		tick(12);
		RST_N = 1'b1;
		test_power();
		test_load();
		test_run();
		test_rerun();
		close_out();
	end
endmodule // test_boot_kernel_sequencer
bind bks_top bks_top_properties #(.RESET_CYCLES(RESET_CYCLES),
	.KICK_LIMIT(2 * WDOG_HALF_CYCLES)) i_chk (
	.CLOCK(CLOCK), .RST_N(RST_N), .SUPPLY_OK(SUPPLY_OK), .ADDR(ADDR), .RD_N(RD_N),
	.ROM_SELECT_N(ROM_SELECT_N), .SRAM_SELECT_N(SRAM_SELECT_N), .PROC_RESET_N(PROC_RESET_N),
	.MODE_C(MODE_C), .MODE_B(MODE_B), .KEY_INTERRUPT_N_OE_N(KEY_INTERRUPT_N_OE_N),
	.BOOT_PAGE_SELECT(BOOT_PAGE_SELECT), .LOAD_OK_FLAG(LOAD_OK_FLAG),
	.WATCHDOG_KICK(WATCHDOG_KICK));
